// [rtl/lec_link_enh_ctrl.sv]
`timescale 1ns/1ps
module lec_link_enh_ctrl #(
    parameter int LEVEL_W = 13
) (
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    // configuration access
    input  wire logic               cfg_wr_i,
    input  wire logic               cfg_rd_i,
    input  wire logic [7:0]         cfg_addr_i,
    input  wire logic [3:0]         cfg_be_i,
    input  wire logic [31:0]        cfg_wdata_i,
    output logic      [31:0]        cfg_rdata_o,
    output logic                    cfg_rvalid_o,
    // serial eeprom preload
    input  wire logic               eeprom_load_i,
    input  wire logic [15:0]        eeprom_data_i,
    // host controller side
    input  wire logic               phy_enhancement_gate_i,
    input  wire logic               link_power_status_clear_i,
    output logic                    link_power_status_clear_o,
    input  wire logic               xfer_bit9_req_i,
    output logic                    xfer_bit9_set_o,
    output logic                    async_tx_reorder_disable_o,
    // asynchronous transmit fifo
    input  wire logic               at_retries_zero_i,
    input  wire logic               pkt_pending_i,
    input  wire logic               pkt_complete_i,
    input  wire logic [LEVEL_W-1:0] fifo_level_i,
    input  wire logic               fifo_empty_i,
    input  wire logic               tx_done_i,
    output logic                    tx_start_o,
    output logic                    underrun_o,
    output logic                    store_forward_o,
    output logic                    tx_busy_o
);

    // stored fields
    logic                  reorder_q;
    logic                  reorder_d;
    logic                  draft_q;
    logic                  draft_d;
    logic [1:0]            thr_q;
    logic [1:0]            thr_d;
    logic                  fallback_q;
    logic                  fallback_d;
    logic [31:0]           rdata_q;
    logic                  rvalid_q;
    logic                  lps_clr_q;
    logic                  bit9_q;
    logic                  start_q;
    logic                  underrun_q;
    lec_pkg::lec_tx_state_t state_q;
    lec_pkg::lec_tx_state_t state_d;

    // decode
    wire        hit_reg    = (cfg_addr_i == lec_pkg::LEC_OFFSET);
    wire        wr_lane1   = cfg_wr_i & hit_reg & cfg_be_i[1];
    wire        rd_hit     = cfg_rd_i & hit_reg;

    // effective enhancement bits
    wire        reorder_eff = reorder_q & phy_enhancement_gate_i;
    wire        draft_eff   = draft_q & phy_enhancement_gate_i;
    wire [1:0]  thr_eff     = phy_enhancement_gate_i ? thr_q : lec_pkg::LEC_THR_4K;

    wire        sf_mode     = (thr_eff == lec_pkg::LEC_THR_4K)
                            | fallback_q
                            | at_retries_zero_i;

    wire        thr_hit;
    wire        go_tx       = pkt_complete_i | (~sf_mode & thr_hit);
    wire        drained     = fifo_empty_i & ~pkt_complete_i;

    // read image: upper half and bit 11 stay zero
    wire [31:0] rd_image    = {16'h0000,
                               reorder_q, draft_q, thr_q,
                               1'b0,
                               11'h000};

    lec_thresh_cmp #(
        .LEVEL_W      (LEVEL_W)
    ) u_thr (
        .thr_sel_i    (thr_eff),
        .fifo_level_i (fifo_level_i),
        .thr_hit_o    (thr_hit)
    );

    // field updates: eeprom preload wins over a same-cycle write
    always_comb begin
        reorder_d = reorder_q;
        draft_d   = draft_q;
        thr_d     = thr_q;
        if (eeprom_load_i) begin
            reorder_d = eeprom_data_i[lec_pkg::LEC_BIT_REORDER];
            draft_d   = eeprom_data_i[lec_pkg::LEC_BIT_DRAFT];
            thr_d     = eeprom_data_i[lec_pkg::LEC_BIT_THR_HI:lec_pkg::LEC_BIT_THR_LO];
        end else if (wr_lane1) begin
            reorder_d = cfg_wdata_i[lec_pkg::LEC_BIT_REORDER];
            draft_d   = cfg_wdata_i[lec_pkg::LEC_BIT_DRAFT];
            thr_d     = cfg_wdata_i[lec_pkg::LEC_BIT_THR_HI:lec_pkg::LEC_BIT_THR_LO];
        end
    end

    // transmit start sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            lec_pkg::LEC_ST_IDLE: begin
                if (pkt_pending_i) begin
                    state_d = lec_pkg::LEC_ST_FILL;
                end
            end
            lec_pkg::LEC_ST_FILL: begin
                if (go_tx) begin
                    state_d = lec_pkg::LEC_ST_XMIT;
                end
            end
            lec_pkg::LEC_ST_XMIT: begin
                if (tx_done_i) begin
                    state_d = lec_pkg::LEC_ST_IDLE;
                end else if (drained) begin
                    state_d = lec_pkg::LEC_ST_FILL;
                end
            end
            default: begin
                state_d = lec_pkg::LEC_ST_IDLE;
            end
        endcase
    end

    wire do_start    = (state_q == lec_pkg::LEC_ST_FILL) & go_tx;
    wire do_underrun = (state_q == lec_pkg::LEC_ST_XMIT) & ~tx_done_i & drained;

    // fallback sticks after underrun until software or an eeprom preload rewrites the field
    always_comb begin
        fallback_d = fallback_q;
        if (do_underrun) begin
            fallback_d = 1'b1;
        end else if (wr_lane1 | eeprom_load_i) begin
            fallback_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reorder_q <= lec_pkg::LEC_RESET_VALUE[lec_pkg::LEC_BIT_REORDER];
            draft_q   <= lec_pkg::LEC_RESET_VALUE[lec_pkg::LEC_BIT_DRAFT];
            thr_q     <= lec_pkg::LEC_RESET_VALUE[lec_pkg::LEC_BIT_THR_HI:lec_pkg::LEC_BIT_THR_LO];
            fallback_q <= 1'b0;
            state_q   <= lec_pkg::LEC_ST_IDLE;
        end else begin
            reorder_q <= reorder_d;
            draft_q   <= draft_d;
            thr_q     <= thr_d;
            fallback_q <= fallback_d;
            state_q   <= state_d;
        end
    end

    // read answer and strobes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_q    <= 32'h0000_0000;
            rvalid_q   <= 1'b0;
            lps_clr_q  <= 1'b0;
            bit9_q     <= 1'b0;
            start_q    <= 1'b0;
            underrun_q <= 1'b0;
        end else begin
            rdata_q    <= rd_hit ? rd_image : 32'h0000_0000;
            rvalid_q   <= rd_hit;
            lps_clr_q  <= link_power_status_clear_i & draft_eff;
            bit9_q     <= xfer_bit9_req_i & draft_eff;
            start_q    <= do_start;
            underrun_q <= do_underrun;
        end
    end

    assign cfg_rdata_o                = rdata_q;
    assign cfg_rvalid_o               = rvalid_q;
    assign link_power_status_clear_o  = lps_clr_q;
    assign xfer_bit9_set_o            = bit9_q;
    assign async_tx_reorder_disable_o = reorder_eff;
    assign tx_start_o                 = start_q;
    assign underrun_o                 = underrun_q;
    assign store_forward_o            = sf_mode;
    assign tx_busy_o                  = (state_q == lec_pkg::LEC_ST_XMIT);

endmodule

// [rtl/lec_pkg.sv]
package lec_pkg;

    localparam logic [7:0]  LEC_OFFSET       = 8'hF4;
    localparam logic [31:0] LEC_RESET_VALUE  = 32'h0000_4000;

    localparam int          LEC_BIT_REORDER  = 15;
    localparam int          LEC_BIT_DRAFT    = 14;
    localparam int          LEC_BIT_THR_HI   = 13;
    localparam int          LEC_BIT_THR_LO   = 12;
    localparam int          LEC_BIT_RSVD11   = 11;

    localparam logic [1:0]  LEC_THR_4K       = 2'h0;
    localparam logic [1:0]  LEC_THR_1K7      = 2'h1;
    localparam logic [1:0]  LEC_THR_1K       = 2'h2;
    localparam logic [1:0]  LEC_THR_512      = 2'h3;

    localparam int          LEC_LEVEL_W      = 13;
    localparam logic [12:0] LEC_BYTES_4K     = 13'h1000;
    localparam logic [12:0] LEC_BYTES_1K7    = 13'h06CD;
    localparam logic [12:0] LEC_BYTES_1K     = 13'h0400;
    localparam logic [12:0] LEC_BYTES_512    = 13'h0200;

    typedef enum logic [2:0] {
        LEC_ST_IDLE = 3'h1,
        LEC_ST_FILL = 3'h2,
        LEC_ST_XMIT = 3'h4
    } lec_tx_state_t;

endpackage

// [rtl/lec_thresh_cmp.sv]
`timescale 1ns/1ps
module lec_thresh_cmp #(
    parameter int LEVEL_W = 13
) (
    input  wire logic [1:0]         thr_sel_i,
    input  wire logic [LEVEL_W-1:0] fifo_level_i,
    output logic                    thr_hit_o
);

    logic [LEVEL_W-1:0] limit;

    // threshold in bytes per start level code
    assign limit = (thr_sel_i == lec_pkg::LEC_THR_1K7) ? LEVEL_W'(lec_pkg::LEC_BYTES_1K7) :
                   (thr_sel_i == lec_pkg::LEC_THR_1K)  ? LEVEL_W'(lec_pkg::LEC_BYTES_1K)  :
                   (thr_sel_i == lec_pkg::LEC_THR_512) ? LEVEL_W'(lec_pkg::LEC_BYTES_512) :
                                                         LEVEL_W'(lec_pkg::LEC_BYTES_4K);

    assign thr_hit_o = (fifo_level_i >= limit);

endmodule

// [testbench/lec_link_enh_ctrl_properties.sv]
`timescale 1ns/1ps
module lec_link_enh_ctrl_properties #(
    parameter int LEVEL_W = 13
) (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        cfg_rd_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_rvalid_o,
    input wire logic        phy_enhancement_gate_i,
    input wire logic        link_power_status_clear_i,
    input wire logic        link_power_status_clear_o,
    input wire logic        xfer_bit9_req_i,
    input wire logic        xfer_bit9_set_o,
    input wire logic        async_tx_reorder_disable_o,
    input wire logic        at_retries_zero_i,
    input wire logic        pkt_complete_i,
    input wire logic        tx_start_o,
    input wire logic        underrun_o,
    input wire logic        store_forward_o,
    input wire logic        tx_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_RD_ANSWER: assert property (cfg_rd_i && cfg_addr_i == 8'hF4 |=> cfg_rvalid_o)
        else $error("read not answered");
    AST_UPPER_ZERO: assert property (cfg_rvalid_o |-> cfg_rdata_o[31:16] == 16'h0000)
        else $error("upper half not zero");
    AST_BIT11_ZERO: assert property (cfg_rvalid_o |-> !cfg_rdata_o[11])
        else $error("bit 11 not zero");
    AST_GATE_REORDER: assert property (async_tx_reorder_disable_o |-> phy_enhancement_gate_i)
        else $error("reorder disable without gate");
    AST_LPS_CLEAR: assert property (link_power_status_clear_o |-> $past(link_power_status_clear_i && phy_enhancement_gate_i))
        else $error("link power clear without cause");
    AST_BIT9_SET: assert property (xfer_bit9_set_o |-> $past(xfer_bit9_req_i && phy_enhancement_gate_i))
        else $error("bit 9 set without cause");
    AST_FORCED_SF: assert property (at_retries_zero_i || !phy_enhancement_gate_i |-> store_forward_o)
        else $error("store and forward not forced");
    AST_SF_WHOLE: assert property (tx_start_o && $past(store_forward_o) |-> $past(pkt_complete_i))
        else $error("partial packet sent in store and forward");
    AST_UNDERRUN: assert property (underrun_o |-> store_forward_o && !tx_busy_o)
        else $error("no fallback on underrun");
    AST_START_PULSE: assert property (tx_start_o |-> tx_busy_o ##1 !tx_start_o)
        else $error("start pulse malformed");
endmodule
bind lec_link_enh_ctrl lec_link_enh_ctrl_properties #(.LEVEL_W(LEVEL_W)) u_props (.*);

// [testbench/lec_link_enh_ctrl_tb.sv]
`timescale 1ns/1ps
module lec_link_enh_ctrl_tb;
    typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] x;} lec_row_t;
    logic        core_clk_i, rst_i, cfg_wr_i, cfg_rd_i, eeprom_load_i, cfg_rvalid_o, tx_done_i;
    logic [7:0]  cfg_addr_i;
    logic [3:0]  cfg_be_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o;
    logic [15:0] eeprom_data_i;
    logic [12:0] fifo_level_i;
    logic        phy_enhancement_gate_i, link_power_status_clear_i, link_power_status_clear_o;
    logic        xfer_bit9_req_i, xfer_bit9_set_o, async_tx_reorder_disable_o, at_retries_zero_i;
    logic        pkt_pending_i, pkt_complete_i, fifo_empty_i, tx_start_o, underrun_o;
    logic        store_forward_o, tx_busy_o;
    logic [1:0]  ev;
    int          num_errors, checks;
    lec_row_t    rows [6];
    lec_link_enh_ctrl #(.LEVEL_W(13)) u_lec_link_enh_ctrl (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_be_i <= be;
        cfg_wdata_i <= d;
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic v, input logic [31:0] exp);
        @(posedge core_clk_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge core_clk_i);
        cfg_rd_i <= 1'b0;
        #1;
        chk({31'h0, cfg_rvalid_o}, {31'h0, v});
        chk(cfg_rdata_o, exp);
    endtask
    task automatic wev();
        ev = 2'b00;
        for (int i = 0; i < 6 && ev == 2'b00; i++) begin
            @(posedge core_clk_i);
            #1;
            ev = {tx_start_o, underrun_o};
        end
    endtask
    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (3000) @(posedge core_clk_i);
        num_errors++;
        conclude();
    end
    initial begin
        {cfg_wr_i, cfg_rd_i, eeprom_load_i, link_power_status_clear_i, xfer_bit9_req_i} = '0;
        {at_retries_zero_i, pkt_pending_i, pkt_complete_i, fifo_empty_i, tx_done_i} = '0;
        {cfg_addr_i, cfg_be_i, cfg_wdata_i, eeprom_data_i, fifo_level_i} = '0;
        {rst_i, phy_enhancement_gate_i} = 2'b11;
        num_errors = 0;
        checks = 0;
        rows = '{'{8'hF4, 4'h2, 32'hFFFF_FFFF, 32'h0000_F000}, '{8'hF4, 4'h1, 32'h0, 32'h0000_F000},
                 '{8'hF8, 4'h2, 32'h0, 32'h0000_F000}, '{8'hF4, 4'h2, 32'h1000, 32'h0000_1000},
                 '{8'hF4, 4'h2, 32'h2000, 32'h0000_2000}, '{8'hF4, 4'h2, 32'h7000, 32'h0000_7000}};
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(8'hF4, 1'b1, 32'h0000_4000);
        chk({31'h0, store_forward_o}, 32'h1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].be, rows[i].d);
            rd(8'hF4, 1'b1, rows[i].x);
        end
        rd(8'hF8, 1'b0, 32'h0);
        @(posedge core_clk_i);
        link_power_status_clear_i <= 1'b1;
        xfer_bit9_req_i <= 1'b1;
        @(posedge core_clk_i);
        link_power_status_clear_i <= 1'b0;
        #1;
        chk({link_power_status_clear_o, xfer_bit9_set_o, store_forward_o}, 32'h6);
        @(posedge core_clk_i);
        link_power_status_clear_i <= 1'b1;
        phy_enhancement_gate_i <= 1'b0;
        @(posedge core_clk_i);
        link_power_status_clear_i <= 1'b0;
        #1;
        chk({link_power_status_clear_o, xfer_bit9_set_o, store_forward_o}, 32'h1);
        @(posedge core_clk_i);
        {phy_enhancement_gate_i, xfer_bit9_req_i, at_retries_zero_i} <= 3'b101;
        #1;
        chk({31'h0, store_forward_o}, 32'h1);
        @(posedge core_clk_i);
        {at_retries_zero_i, pkt_pending_i, fifo_level_i} <= {2'b01, 13'h01FF};
        wev();
        chk({30'h0, ev}, 32'h0);
        fifo_level_i <= 13'h0200;
        wev();
        chk({30'h0, ev}, 32'h2);
        @(posedge core_clk_i);
        fifo_empty_i <= 1'b1;
        wev();
        chk({29'h0, ev, store_forward_o}, 32'h3);
        fifo_empty_i <= 1'b0;
        wev();
        chk({30'h0, ev}, 32'h0);
        pkt_complete_i <= 1'b1;
        wev();
        chk({30'h0, ev}, 32'h2);
        tx_done_i <= 1'b1;
        @(posedge core_clk_i);
        {tx_done_i, pkt_pending_i, pkt_complete_i} <= 3'b000;
        #1;
        chk({31'h0, tx_busy_o}, 32'h0);
        @(posedge core_clk_i);
        eeprom_load_i <= 1'b1;
        eeprom_data_i <= 16'hB000;
        @(posedge core_clk_i);
        eeprom_load_i <= 1'b0;
        rd(8'hF4, 1'b1, 32'h0000_B000);
        chk({31'h0, async_tx_reorder_disable_o}, 32'h1);
        phy_enhancement_gate_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk({31'h0, async_tx_reorder_disable_o}, 32'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(8'hF4, 1'b1, 32'h0000_4000);
        wr(8'hF4, 4'h2, 32'h0000_1000);
        {phy_enhancement_gate_i, pkt_pending_i, fifo_level_i} <= {2'b11, 13'h06CC};
        wev();
        chk({30'h0, ev}, 32'h0);
        fifo_level_i <= 13'h06CD;
        wev();
        chk({30'h0, ev}, 32'h2);
        conclude();
    end
endmodule
